// >>> pkg/flash_cycle_if.sv
`timescale 1ns/1ns
// Purpose: request and answer between sequencer and pin cycle engine
// Assumes: one clock, pclk
// Notes:   start is a one-cycle pulse, done a one-cycle pulse
interface flash_cycle_if;
	logic        start;
	logic        write;
	logic [20:0] addr;
	logic [15:0] wdata;
	logic        done;
	logic [15:0] rdata;
	modport seq (output start, write, addr, wdata, input done, rdata);
	modport eng (input start, write, addr, wdata, output done, rdata);
endinterface

// >>> pkg/flash_host_pkg.sv
// Purpose: constants for the flash write-sequencer host controller
// Assumes: pclk at 20 MHz, APB slave for software, parallel flash pins
// Notes:   register offsets are byte addresses of aligned words
package flash_host_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0] ctrl_off   = 8'h00;
	localparam logic [7:0] addr_off   = 8'h04;
	localparam logic [7:0] wdata_off  = 8'h08;
	localparam logic [7:0] status_off = 8'h0c;
	localparam logic [7:0] rdata_off  = 8'h10;

	// ************************************************************
	// flash command codes
	// ************************************************************
	localparam logic [7:0] cmd_read_array   = 8'hff;
	localparam logic [7:0] cmd_program      = 8'h40;
	localparam logic [7:0] cmd_erase_setup  = 8'h20;
	localparam logic [7:0] cmd_confirm      = 8'hd0;
	localparam logic [7:0] cmd_suspend      = 8'hb0;
	localparam logic [7:0] cmd_read_status  = 8'h70;
	localparam logic [7:0] cmd_clear_status = 8'h50;
	localparam logic [7:0] cmd_prot_setup   = 8'hc0;

	// ************************************************************
	// status bit positions
	// ************************************************************
	localparam int machine_ready_bit   = 7;
	localparam int erase_paused_bit    = 6;
	localparam int erase_fail_bit      = 5;
	localparam int program_fail_bit    = 4;
	localparam int supply_range_bit    = 3;
	localparam int program_paused_bit  = 2;
	localparam int locked_target_bit   = 1;

	// ************************************************************
	// operations requested by software
	// ************************************************************
	typedef enum logic [2:0] {
		op_program, op_erase, op_suspend, op_resume,
		op_read_array, op_read_status, op_clear_status, op_prot_program
	} op_e;

	// ************************************************************
	// pin timing: each bus strobe phase in ns and cycles
	// ************************************************************
	localparam int pclk_mhz      = 20;
	localparam int strobe_ns     = 70;
	localparam int strobe_cycles = (strobe_ns * pclk_mhz + 999) / 1000;
	localparam logic [7:0] reset_status = 8'h00;

endpackage

// >>> verif/flash_device_model.sv
// Purpose: behavioural flash write sequencer and status register
// Assumes: pins sampled on pclk; busy lasts a set number of status polls
// Notes:   sectors with addr[20:15] == 2 are locked, == 3 fail erase;
//          programming the word dead fails
`timescale 1ns/1ns
module flash_device_model #(
	parameter int busy_polls = 2 // status polls before ready
) (
	input  wire logic        pclk,             // sampling clock
	input  wire logic        supply_bad,       // inject supply range error
	input  wire logic [20:0] fl_addr,          // flash address
	input  wire logic        fl_ce_n,          // chip enable
	input  wire logic        fl_oe_n,          // output enable
	input  wire logic        fl_we_n,          // write enable
	input  wire logic [15:0] fl_dq_o,          // data from host
	input  wire logic        fl_dq_oe,         // host drives data
	output logic      [15:0] fl_dq_i,          // data to host
	output logic      [7:0]  operation_status, // status register
	output logic      [15:0] last_data,        // last programmed word
	output logic      [20:0] last_addr         // last programmed address
);
	logic [6:0]  stat;
	logic [7:0]  setup;
	logic        in_status, we_q, oe_q;
	logic [15:0] wd, lastv;
	logic [20:0] wa;
	int          busy;
	int          held;
	logic        erasing;
	wire         drive = !fl_ce_n && !fl_oe_n;
	initial begin
		{stat, setup, in_status, we_q, oe_q, wd, lastv, wa} = '0;
		busy = 0;
		held = 0;
		erasing = 1'b0;
		last_data = '0;
		last_addr = '0;
	end
	assign operation_status = {busy == 0, stat};
	// released bus shows the inverse of the last value, never a stale copy
	assign fl_dq_i = !drive ? ~lastv : in_status ?
		{~lastv[15:8], operation_status} : ~fl_addr[15:0];
	task automatic exec(input logic [15:0] d, input logic [20:0] a);
		setup <= 8'h00;
		in_status <= 1'b1;
		if (setup == 8'h40) begin
			if (supply_bad || stat[3]) stat[3] <= 1'b1;
			else if (a[20:15] == 6'h02) stat[1] <= 1'b1;
			else if (d == 16'hdead) stat[4] <= 1'b1;
			else begin
				erasing <= 1'b0;
				last_addr <= a;
				last_data <= d;
				busy <= busy_polls;
			end
		end else if (setup == 8'h20) begin
			if (d[7:0] != 8'hd0) stat[5:4] <= 2'b11;
			else if (!stat[1] && !stat[3]) begin
				if (a[20:15] == 6'h02) stat[1] <= 1'b1;
				else if (a[20:15] == 6'h03) stat[5] <= 1'b1;
				else begin
					busy <= busy_polls;
					erasing <= 1'b1;
				end
			end
		end else if (setup == 8'hc0) begin
			if (a[20:8] != 13'h0 || a[7:0] < 8'h81 || a[7:0] > 8'h88)
				stat[4] <= 1'b1;
			else if (supply_bad) stat[4:3] <= 2'b11;
			else busy <= busy_polls;
		end else case (d[7:0])
			8'h40, 8'h20, 8'hc0: setup <= d[7:0];
			8'hff: in_status <= 1'b0;
			// pause bits are not errors, so clear-status leaves them
			8'h50: {stat[5:3], stat[1]} <= 4'h0;
			// suspend of a finished operation leaves pause bits at 0
			8'hb0: if (busy > 0) begin
				if (erasing) stat[6] <= 1'b1;
				else stat[2] <= 1'b1;
				held <= busy;
				busy <= 0;
			end
			8'hd0: if (stat[6] || stat[2]) begin
				stat[6] <= 1'b0;
				stat[2] <= 1'b0;
				busy <= held;
			end
			default: ;
		endcase
	endtask
	always @(posedge pclk) begin
		we_q <= fl_we_n;
		oe_q <= fl_oe_n;
		if (drive) lastv <= fl_dq_i;
		if (!fl_we_n && !fl_ce_n && fl_dq_oe) begin
			wd <= fl_dq_o;
			wa <= fl_addr;
		end
		if (oe_q && !fl_oe_n && in_status && busy > 0) busy <= busy - 1;
		if (!we_q && fl_we_n) exec(wd, wa);
	end
endmodule

// >>> verif/flash_host_assertions.sv
// Purpose: port checks for flash_host
// Assumes: 5-cycle strobe and 3-cycle idle per pin cycle
// Notes:   bound from the bench top file
`timescale 1ns/1ns
module flash_host_assertions (
	input wire logic        pclk,     // clock
	input wire logic        presetn,  // async reset, active low
	input wire logic        psel,     // apb select
	input wire logic        penable,  // apb enable
	input wire logic        pready,   // apb ready
	input wire logic        pslverr,  // apb error
	input wire logic [20:0] fl_addr,  // flash address
	input wire logic        fl_ce_n,  // chip enable, active low
	input wire logic        fl_oe_n,  // output enable, active low
	input wire logic        fl_we_n,  // write enable, active low
	input wire logic        fl_dq_oe  // data drive enable
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ****************************************
	// checks
	// ****************************************
	a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("pready not one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_slverr_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_strobe_width: assert property ($fell(fl_ce_n) |-> !fl_ce_n [*5] ##1 fl_ce_n)
		else $error("chip enable strobe width wrong");
	a_ce_gap: assert property ($rose(fl_ce_n) |-> fl_ce_n [*3])
		else $error("chip enable gap too short");
	a_we_oe_apart: assert property (!(!fl_we_n && !fl_oe_n))
		else $error("write and output enable both low");
	a_write_drives: assert property (!fl_we_n |-> fl_dq_oe && !fl_ce_n)
		else $error("write strobe without data drive");
	a_read_released: assert property (!fl_oe_n |-> !fl_dq_oe && !fl_ce_n)
		else $error("host drives data during read");
	a_addr_steady: assert property (!fl_ce_n && !$past(fl_ce_n) |-> $stable(fl_addr))
		else $error("address moved inside strobe");
endmodule

// >>> verif/flash_host_tb.sv
// Purpose: self-checking bench for flash_host
// Assumes: apb answers with one wait state
// Notes:   device model counts status polls as busy time
`timescale 1ns/1ns
module flash_host_tb;
	import flash_host_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic        fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe, supply_bad;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [20:0] fl_addr, seen_addr;
	logic [15:0] fl_dq_o, fl_dq_i, seen_data;
	int          n_fail, n_compared;
	flash_host u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .fl_addr, .fl_ce_n, .fl_oe_n,
		.fl_we_n, .fl_dq_o, .fl_dq_oe, .fl_dq_i);
	flash_device_model #(.busy_polls(2)) u_flash (.pclk, .supply_bad,
		.fl_addr, .fl_ce_n, .fl_oe_n, .fl_we_n, .fl_dq_o, .fl_dq_oe, .fl_dq_i,
		.operation_status(), .last_data(seen_data), .last_addr(seen_addr));
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic give_verdict;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			n_fail++;
			give_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wait_idle;
		int k;
		k = 0;
		do begin
			apb(1'b0, status_off, 32'h0);
			k++;
		end while (rd[8] !== 1'b0 && k < 400);
		if (k >= 400) begin
			n_fail++;
			give_verdict();
		end
	endtask
	task automatic run_op(input op_e op, input logic [20:0] a,
		input logic [15:0] d);
		apb(1'b1, addr_off, {11'h0, a});
		apb(1'b1, wdata_off, {16'h0, d});
		apb(1'b1, ctrl_off, {29'h0, op});
		wait_idle();
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_program;
		run_op(op_program, 21'h000123, 16'h5a5a);
		check("prog status", rd[7:0], 8'h80);
		check("prog addr", seen_addr, 21'h000123);
		check("prog data", seen_data, 16'h5a5a);
	endtask
	task automatic t_lock;
		run_op(op_erase, 21'h012000, 16'h0);
		check("lock status", rd[7:0], 8'h82);
		run_op(op_program, 21'h000200, 16'h1234);
		check("refused", rd[9], 1'b1);
		run_op(op_read_status, 21'h0, 16'h0);
		check("kept", rd[7:0], 8'h82);
		run_op(op_clear_status, 21'h0, 16'h0);
		run_op(op_read_status, 21'h0, 16'h0);
		check("cleared", rd[7:0], 8'h80);
	endtask
	task automatic t_prot;
		supply_bad <= 1'b1;
		run_op(op_prot_program, 21'h000085, 16'hbeef);
		check("prot supply", rd[7:0], 8'h98);
		supply_bad <= 1'b0;
		run_op(op_clear_status, 21'h0, 16'h0);
		run_op(op_prot_program, 21'h000100, 16'hbeef);
		check("prot outside", rd[7:0], 8'h90);
		run_op(op_clear_status, 21'h0, 16'h0);
	endtask
	task automatic t_busy;
		apb(1'b1, addr_off, 32'h030000);
		apb(1'b1, ctrl_off, {29'h0, op_erase});
		apb(1'b1, ctrl_off, {29'h0, op_program});
		apb(1'b0, status_off, 32'h0);
		check("busy refused", rd[9:8], 2'b11);
		wait_idle();
		check("erase done", rd[7:0], 8'h80);
		run_op(op_suspend, 21'h0, 16'h0);
		check("idle suspend", rd[7:0], 8'h80);
	endtask
	task automatic t_read;
		run_op(op_read_array, 21'h00abcd, 16'h0);
		apb(1'b0, rdata_off, 32'h0);
		check("array word", rd[15:0], 16'h5432);
		apb(1'b0, 8'h14, 32'h0);
		check("unmapped", err, 1'b1);
	endtask
	task automatic t_fail;
		run_op(op_program, 21'h000300, 16'hdead);
		check("prog fail", rd[7:0], 8'h90);
		run_op(op_erase, 21'h018000, 16'h0);
		check("errors kept", rd[7:0], 8'hb0);
		run_op(op_clear_status, 21'h0, 16'h0);
		run_op(op_erase, 21'h018000, 16'h0);
		check("erase fail", rd[7:0], 8'ha0);
		run_op(op_clear_status, 21'h0, 16'h0);
	endtask
	task automatic t_suspend;
		apb(1'b1, addr_off, 32'h040000);
		apb(1'b1, ctrl_off, {29'h0, op_erase});
		apb(1'b1, ctrl_off, {29'h0, op_suspend});
		wait_idle();
		check("erase paused", rd[7:0], 8'hc0);
		run_op(op_resume, 21'h0, 16'h0);
		check("erase resumed", rd[7:0], 8'h80);
		apb(1'b1, addr_off, 32'h000400);
		apb(1'b1, ctrl_off, {29'h0, op_program});
		apb(1'b1, ctrl_off, {29'h0, op_suspend});
		wait_idle();
		check("prog paused", rd[7:0], 8'h84);
		run_op(op_resume, 21'h0, 16'h0);
		check("prog resumed", rd[7:0], 8'h80);
	endtask
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, supply_bad} = '0;
		n_fail = 0;
		n_compared = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, status_off, 32'h0);
		check("reset status", rd, {24'h0, reset_status});
		t_program();
		t_lock();
		t_prot();
		t_busy();
		t_read();
		t_fail();
		t_suspend();
		give_verdict();
	end
endmodule
bind flash_host flash_host_assertions u_chk (.pclk, .presetn, .psel,
	.penable, .pready, .pslverr, .fl_addr, .fl_ce_n, .fl_oe_n, .fl_we_n,
	.fl_dq_oe);

// >>> verilog/flash_bus_cycle.sv
`timescale 1ns/1ns
// Purpose: runs one asynchronous write or read cycle on the flash pins
// Assumes: data pins synchronised by two flops before sampling
// Notes:   chip and output enable are released after every cycle
module flash_bus_cycle
	import flash_host_pkg::*;
(
	input  wire logic        pclk,        // clock
	input  wire logic        presetn,     // async reset, active low
	flash_cycle_if.eng       cyc,         // request from sequencer
	output logic [20:0]      fl_addr,     // flash address
	output logic             fl_ce_n,     // chip enable, active low
	output logic             fl_oe_n,     // output enable, active low
	output logic             fl_we_n,     // write enable, active low
	output logic [15:0]      fl_dq_o,     // data out
	output logic             fl_dq_oe,    // data drive enable
	input  wire logic [15:0] fl_dq_i      // data in
);
	typedef enum logic [1:0] {c_idle, c_strobe, c_hold} cst_e;
	typedef struct packed {
		cst_e        st;
		logic [7:0]  cnt;
		logic        wr;
		logic [20:0] addr;
		logic [15:0] wd;
		logic [15:0] rd;
		logic        done;
		logic [15:0] s1;
		logic [15:0] s2;
	} cyc_s;
	cyc_s q, d;

	always_comb begin
		d = q;
		d.done = 1'b0;
		d.s1 = fl_dq_i;
		d.s2 = q.s1;
		unique case (q.st)
			c_idle: if (cyc.start) begin
				d.st = c_strobe;
				d.wr = cyc.write;
				d.addr = cyc.addr;
				d.wd = cyc.wdata;
				d.cnt = 8'(strobe_cycles + 2);
			end
			c_strobe: if (q.cnt == 8'h00) begin
				d.rd = q.s2;
				d.st = c_hold;
				d.cnt = 8'(strobe_cycles);
			end else begin
				d.cnt = q.cnt - 8'h01;
			end
			c_hold: if (q.cnt == 8'h00) begin
				d.st = c_idle;
				d.done = 1'b1;
			end else begin
				d.cnt = q.cnt - 8'h01;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// strobes de-asserted between cycles so each poll refreshes status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fl_ce_n  <= 1'b1;
			fl_oe_n  <= 1'b1;
			fl_we_n  <= 1'b1;
			fl_dq_oe <= 1'b0;
			fl_addr  <= '0;
			fl_dq_o  <= '0;
		end else begin
			fl_ce_n  <= (d.st != c_strobe);
			fl_oe_n  <= !(d.st == c_strobe && !d.wr);
			fl_we_n  <= !(d.st == c_strobe && d.wr);
			fl_dq_oe <= (d.st != c_idle) && d.wr;
			fl_addr  <= d.addr;
			fl_dq_o  <= d.wd;
		end
	end

	assign cyc.done  = q.done;
	assign cyc.rdata = q.rd;
endmodule

// >>> verilog/flash_host.sv
`timescale 1ns/1ns
// Purpose: APB-controlled host that sequences flash program/erase commands
// Assumes: device keeps its own status rules; host only polls and reacts
// Notes:   one operation at a time; busy until status shows ready, or until the last cycle ends for clear-status and read-array
module flash_host
	import flash_host_pkg::*;
(
	input  wire logic        pclk,       // clock
	input  wire logic        presetn,    // async reset, active low
	input  wire logic        psel,       // apb select
	input  wire logic        penable,    // apb enable
	input  wire logic        pwrite,     // apb direction
	input  wire logic [7:0]  paddr,      // apb byte address
	input  wire logic [31:0] pwdata,     // apb write data
	output logic [31:0]      prdata,     // apb read data
	output logic             pready,     // apb ready
	output logic             pslverr,    // apb error
	output logic [20:0]      fl_addr,    // flash address
	output logic             fl_ce_n,    // chip enable, active low
	output logic             fl_oe_n,    // output enable, active low
	output logic             fl_we_n,    // write enable, active low
	output logic [15:0]      fl_dq_o,    // data out
	output logic             fl_dq_oe,   // data drive enable
	input  wire logic [15:0] fl_dq_i     // data in
);
	typedef enum logic [2:0] {
		s_idle, s_first, s_second, s_status_cmd, s_poll, s_single
	} st_e;

	typedef struct packed {
		st_e         st;
		op_e         op;
		logic [20:0] addr;
		logic [15:0] wd;
		logic [7:0]  status;
		logic [15:0] rdata;
		logic        busy;
		logic        refused;
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
		logic        launched;
		logic        susp_pend;
	} host_s;
	host_s q, d;

	flash_cycle_if cyc ();

	flash_bus_cycle u_cycle (
		.pclk     (pclk),
		.presetn  (presetn),
		.cyc      (cyc),
		.fl_addr  (fl_addr),
		.fl_ce_n  (fl_ce_n),
		.fl_oe_n  (fl_oe_n),
		.fl_we_n  (fl_we_n),
		.fl_dq_o  (fl_dq_o),
		.fl_dq_oe (fl_dq_oe),
		.fl_dq_i  (fl_dq_i)
	);

	function automatic logic [15:0] cmd16(input logic [7:0] c);
		return {8'h00, c};
	endfunction

	// two-cycle operations hold their command in the first write
	function automatic logic [7:0] setup_code(input op_e o);
		unique case (o)
			op_program:      return cmd_program;
			op_erase:        return cmd_erase_setup;
			op_prot_program: return cmd_prot_setup;
			op_suspend:      return cmd_suspend;
			op_resume:       return cmd_confirm;
			op_read_array:   return cmd_read_array;
			op_read_status:  return cmd_read_status;
			op_clear_status: return cmd_clear_status;
		endcase
	endfunction

	logic apb_wr;
	logic apb_rd;
	logic err_lock;

	assign apb_wr = psel && penable && pwrite && !q.pready;
	assign apb_rd = psel && penable && !pwrite && !q.pready;
	// host mirrors device refusal: program and erase are refused while the supply-range or locked status bit is set
	assign err_lock = q.status[supply_range_bit]
		|| q.status[locked_target_bit];

	always_comb begin
		d = q;
		d.pready = 1'b0;
		d.pslverr = 1'b0;
		cyc.start = 1'b0;
		cyc.write = 1'b1;
		cyc.addr = q.addr;
		cyc.wdata = cmd16(setup_code(q.op));

		// ************************************************************
		// apb slave
		// ************************************************************
		if (apb_wr) begin
			d.pready = 1'b1;
			unique case (paddr)
				ctrl_off: begin
					// suspend is the one order taken while busy, and only while busy with program or erase
					if (q.busy && op_e'(pwdata[2:0]) == op_suspend
						&& (q.op == op_program || q.op == op_erase)) begin
						d.susp_pend = 1'b1;
					end else if (q.busy || (err_lock
						&& (op_e'(pwdata[2:0]) == op_program
						|| op_e'(pwdata[2:0]) == op_erase))) begin
						d.refused = 1'b1;
					end else begin
						d.op = op_e'(pwdata[2:0]);
						d.busy = 1'b1;
						d.refused = 1'b0;
						d.launched = 1'b0;
						d.st = s_first;
					end
				end
				addr_off:  d.addr = pwdata[20:0];
				wdata_off: d.wd = pwdata[15:0];
				status_off, rdata_off: ;
				default: d.pslverr = 1'b1;
			endcase
		end else if (apb_rd) begin
			d.pready = 1'b1;
			unique case (paddr)
				ctrl_off:   d.prdata = {29'h0, q.op};
				addr_off:   d.prdata = {11'h0, q.addr};
				wdata_off:  d.prdata = {16'h0, q.wd};
				status_off: d.prdata = {22'h0, q.refused, q.busy, q.status};
				rdata_off:  d.prdata = {16'h0, q.rdata};
				default: begin
					d.prdata = 32'h0;
					d.pslverr = 1'b1;
				end
			endcase
		end

		// ************************************************************
		// command sequencer
		// ************************************************************
		unique case (q.st)
			s_idle: ;
			s_first: begin
				cyc.start = !q.launched;
				d.launched = 1'b1;
				if (cyc.done) begin
					d.launched = 1'b0;
					unique case (q.op)
						op_program, op_erase, op_prot_program: d.st = s_second;
						op_read_status: d.st = s_poll;
						op_suspend, op_resume: d.st = s_status_cmd;
						default: begin
							d.st = s_idle;
							d.busy = 1'b0;
						end
					endcase
				end
			end
			s_second: begin
				// same word or sector address as the setup write
				cyc.start = !q.launched;
				cyc.wdata = (q.op == op_erase) ? cmd16(cmd_confirm) : q.wd;
				d.launched = 1'b1;
				if (cyc.done) begin
					d.launched = 1'b0;
					d.st = s_status_cmd;
				end
			end
			s_status_cmd: begin
				cyc.start = !q.launched;
				cyc.wdata = cmd16(cmd_read_status);
				d.launched = 1'b1;
				if (cyc.done) begin
					d.launched = 1'b0;
					d.st = s_poll;
				end
			end
			s_poll: begin
				// each poll is a fresh read cycle with enables toggled
				cyc.start = !q.launched;
				cyc.write = 1'b0;
				d.launched = 1'b1;
				if (cyc.done) begin
					d.launched = 1'b0;
					d.status = cyc.rdata[7:0];
					// pending suspend goes out between polls, never mid-cycle
					if (q.susp_pend) begin
						d.susp_pend = 1'b0;
						d.op = op_suspend;
						d.st = s_first;
					end else if (cyc.rdata[machine_ready_bit]) begin
						d.st = s_idle;
						d.busy = 1'b0;
					end
				end
			end
			s_single: begin
				cyc.start = !q.launched;
				cyc.write = 1'b0;
				d.launched = 1'b1;
				if (cyc.done) begin
					d.rdata = cyc.rdata;
					d.st = s_idle;
					d.busy = 1'b0;
				end
			end
		endcase

		// array read: read the addressed word after FF
		if (q.st == s_first && cyc.done && q.op == op_read_array) begin
			d.st = s_single;
			d.busy = 1'b1;
		end
		if (q.st == s_first && cyc.done && q.op == op_clear_status) begin
			d.status = reset_status;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign prdata  = q.prdata;
	assign pready  = q.pready;
	assign pslverr = q.pslverr;
endmodule
